/* rtl/blt_pkg.sv */
// Purpose: shared constants for the battery limit threshold registers
// Assumes: 8-bit registers at byte offsets 0..3 of a 7-bit i2c target
// Notes:   voltages in microvolts, currents in tenths of a milliamp
package blt_pkg;

  // register map
  localparam int            NUM_REGS      = 4;
  localparam logic [7:0]    OFF_OVP_LIMIT = 8'h00;
  localparam logic [7:0]    OFF_OVP_ALARM = 8'h01;
  localparam logic [7:0]    OFF_OCP_LIMIT = 8'h02;
  localparam logic [7:0]    OFF_OCP_ALARM = 8'h03;
  localparam logic [7:0]    UNMAPPED_DATA = 8'hff;

  // field layout: disable bit above a 7-bit code
  localparam int            DIS_BIT       = 7;
  localparam int            CODE_W        = 7;

  // reset values, disable bit clear
  localparam logic [7:0]    RST_OVP_LIMIT = 8'h5a;
  localparam logic [7:0]    RST_OVP_ALARM = 8'h46;
  localparam logic [7:0]    RST_OCP_LIMIT = 8'h47;
  localparam logic [7:0]    RST_OCP_ALARM = 8'h46;

  // threshold scaling
  localparam int            VOLT_W         = 23;
  localparam int            CURR_W         = 18;
  localparam int unsigned   OVP_OFFSET_UV  = 3491000;
  localparam int unsigned   OVP_STEP_UV    = 9985;
  localparam int unsigned   OVA_OFFSET_UV  = 3500000;
  localparam int unsigned   OVA_STEP_UV    = 10000;
  localparam int unsigned   OCP_STEP_DMA   = 1025;
  localparam int unsigned   OCA_STEP_DMA   = 1000;
  localparam int unsigned   ZERO_OFFSET    = 0;
  localparam int unsigned   OCP_MIN_CODE   = 20;
  localparam int unsigned   NO_MIN_CODE    = 0;

  // i2c framing
  localparam logic [3:0]    BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0]    LAST_TX_SHIFT  = 4'h7;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_ADDR     = 4'b0001,
    ST_ACK_ADDR = 4'b0010,
    ST_PTR      = 4'b0011,
    ST_ACK_PTR  = 4'b0100,
    ST_WDATA    = 4'b0101,
    ST_ACK_W    = 4'b0110,
    ST_RDATA    = 4'b0111,
    ST_RACK     = 4'b1000
  } blt_state_type;

endpackage

/* rtl/blt_threshold_check.sv */
// Purpose: compares one measurement against one programmed threshold
// Assumes: measurement comes from logic on the same clock
// Notes:   threshold = offset + code * step, codes below min are clamped
module blt_threshold_check
  import blt_pkg::*;
#(
  parameter int          MEAS_W   = VOLT_W,
  parameter int unsigned OFFSET   = ZERO_OFFSET,
  parameter int unsigned STEP     = OVA_STEP_UV,
  parameter int unsigned MIN_CODE = NO_MIN_CODE,
  parameter bit          STRICT   = 1'b0
)
(
  input  wire logic              clock,     // core clock
  input  wire logic              rst_n,     // async reset, active low
  input  wire logic [CODE_W-1:0] code,      // threshold code
  input  wire logic              off,       // disable bit
  input  wire logic [MEAS_W-1:0] meas,      // measured value
  output logic                   trip_reg   // threshold crossed and enabled
);

  localparam logic [CODE_W-1:0] MIN_C = CODE_W'(MIN_CODE);

  logic [CODE_W-1:0] eff_code;
  logic [MEAS_W-1:0] thr;
  logic              hit;

  // clamp below the usable range, then scale to measurement units
  assign eff_code = (code < MIN_C) ? MIN_C : code;
  assign thr = MEAS_W'(OFFSET) + MEAS_W'(MEAS_W'(eff_code) * MEAS_W'(STEP));
  assign hit = STRICT ? (meas > thr) : (meas >= thr);

  // registered comparison, gated by the disable bit
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      trip_reg <= 1'b0;
    else
      trip_reg <= hit && !off;
  end

endmodule

/* rtl/blt_limit_regs.sv */
// Purpose: i2c target with battery overvoltage/overcurrent limit registers
// Assumes: vbat_uv and ibat_dma come from an adc on this clock
// Notes:   scl/sda/addr strap are synchronised; sda is open drain
module blt_limit_regs
  import blt_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR_LO = 7'h10, // arbitrary value
  parameter logic [6:0] TARGET_ADDR_HI = 7'h11  // arbitrary value
)
(
  input  wire logic              clock,          // 250 mhz core clock
  input  wire logic              rst_n,          // async reset, active low
  input  wire logic              reg_reset,      // register reset pulse
  input  wire logic              scl_in,         // i2c clock pin
  input  wire logic              sda_in,         // i2c data pin level
  output logic                   sda_out,        // i2c data drive value
  output logic                   sda_oe,         // high pulls sda low
  input  wire logic              addr_strap,     // target address strap
  input  wire logic [VOLT_W-1:0] vbat_uv,        // battery voltage, uV
  input  wire logic [CURR_W-1:0] ibat_dma,       // battery current, 0.1 mA
  output logic                   fets_off_reg,   // blocking/switch fets off
  output logic                   charge_enable_ctl_clr_reg, // clear charge_enable_ctl
  output logic                   int_n_reg       // interrupt to host
);

  logic [7:0]    regs_reg [NUM_REGS];
  logic          scl_s1_reg;
  logic          scl_s2_reg;
  logic          scl_d_reg;
  logic          sda_s1_reg;
  logic          sda_s2_reg;
  logic          sda_d_reg;
  logic          strap_s1_reg;
  logic          strap_s2_reg;
  logic          strap_done_reg;
  logic [1:0]    strap_fill_reg;
  logic          addr_sel_reg;
  blt_state_type state_reg;
  logic [3:0]    bitcnt_reg;
  logic [7:0]    shift_reg;
  logic [7:0]    tx_reg;
  logic [7:0]    ptr_reg;
  logic          rw_reg;
  logic          nack_reg;
  logic          prot_d_reg;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_det;
  logic          stop_det;
  logic          wr_stb;
  logic [6:0]    my_addr;
  logic [7:0]    rd_data;
  logic          ovp_trip;
  logic          ova_trip;
  logic          ocp_trip;
  logic          oca_trip;
  logic          prot_any;

  // two-flop synchronisers for the pins, plus one delay for edges
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_s1_reg   <= 1'b1;
      scl_s2_reg   <= 1'b1;
      scl_d_reg    <= 1'b1;
      sda_s1_reg   <= 1'b1;
      sda_s2_reg   <= 1'b1;
      sda_d_reg    <= 1'b1;
      strap_s1_reg <= 1'b0;
      strap_s2_reg <= 1'b0;
    end
    else
    begin
      scl_s1_reg   <= scl_in;
      scl_s2_reg   <= scl_s1_reg;
      scl_d_reg    <= scl_s2_reg;
      sda_s1_reg   <= sda_in;
      sda_s2_reg   <= sda_s1_reg;
      sda_d_reg    <= sda_s2_reg;
      strap_s1_reg <= addr_strap;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // strap caught once, after the synchroniser holds a real pin sample;
  // the strap sync flops leave reset at zero, so the first edges see no strap
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_fill_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      addr_sel_reg   <= 1'b0;
    end
    else
    begin
      strap_fill_reg <= {strap_fill_reg[0], 1'b1};
      if (strap_fill_reg[1] && !strap_done_reg)
      begin
        strap_done_reg <= 1'b1;
        addr_sel_reg   <= strap_s2_reg;
      end
    end
  end

  // bus events
  assign scl_rise  = scl_s2_reg && !scl_d_reg;
  assign scl_fall  = !scl_s2_reg && scl_d_reg;
  assign start_det = scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg;
  assign stop_det  = scl_s2_reg && scl_d_reg && !sda_d_reg && sda_s2_reg;
  assign my_addr   = addr_sel_reg ? TARGET_ADDR_HI : TARGET_ADDR_LO;
  assign wr_stb    = scl_fall && (state_reg == ST_WDATA)
                     && (bitcnt_reg == BITS_PER_BYTE);

  // read data mux, unmapped offsets read all ones
  always_comb
  begin
    if (ptr_reg < 8'(NUM_REGS))
      rd_data = regs_reg[ptr_reg[1:0]];
    else
      rd_data = UNMAPPED_DATA;
  end

  // i2c target state machine
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg  <= ST_IDLE;
      bitcnt_reg <= 4'h0;
      shift_reg  <= 8'h00;
      tx_reg     <= 8'h00;
      ptr_reg    <= 8'h00;
      rw_reg     <= 1'b0;
      nack_reg   <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg  <= ST_ADDR;
      bitcnt_reg <= 4'h0;
    end
    else if (stop_det)
      state_reg <= ST_IDLE;
    else if (scl_rise)
    begin
      case (state_reg)
        ST_ADDR, ST_PTR, ST_WDATA:
        begin
          shift_reg  <= {shift_reg[6:0], sda_s2_reg};
          bitcnt_reg <= bitcnt_reg + 4'h1;
        end
        ST_RACK: nack_reg <= sda_s2_reg;
        default: ;
      endcase
    end
    else if (scl_fall)
    begin
      case (state_reg)
        ST_ADDR:
          if (bitcnt_reg == BITS_PER_BYTE)
          begin
            if (shift_reg[7:1] == my_addr)
            begin
              rw_reg    <= shift_reg[0];
              state_reg <= ST_ACK_ADDR;
            end
            else
              state_reg <= ST_IDLE;
          end
        ST_ACK_ADDR:
        begin
          bitcnt_reg <= 4'h0;
          if (rw_reg)
          begin
            tx_reg    <= rd_data;
            state_reg <= ST_RDATA;
          end
          else
            state_reg <= ST_PTR;
        end
        ST_PTR:
          if (bitcnt_reg == BITS_PER_BYTE)
          begin
            ptr_reg   <= shift_reg;
            state_reg <= ST_ACK_PTR;
          end
        ST_ACK_PTR, ST_ACK_W:
        begin
          bitcnt_reg <= 4'h0;
          state_reg  <= ST_WDATA;
        end
        ST_WDATA:
          if (bitcnt_reg == BITS_PER_BYTE)
          begin
            ptr_reg   <= ptr_reg + 8'h01;
            state_reg <= ST_ACK_W;
          end
        ST_RDATA:
          if (bitcnt_reg == LAST_TX_SHIFT)
          begin
            ptr_reg   <= ptr_reg + 8'h01;
            state_reg <= ST_RACK;
          end
          else
          begin
            tx_reg     <= {tx_reg[6:0], 1'b0};
            bitcnt_reg <= bitcnt_reg + 4'h1;
          end
        ST_RACK:
          if (nack_reg)
            state_reg <= ST_IDLE;
          else
          begin
            tx_reg     <= rd_data;
            bitcnt_reg <= 4'h0;
            state_reg  <= ST_RDATA;
          end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // open-drain data: acknowledge slots and zero bits pull low
  always_comb
  begin
    sda_out = 1'b0;
    case (state_reg)
      ST_ACK_ADDR, ST_ACK_PTR, ST_ACK_W: sda_oe = 1'b1;
      ST_RDATA:                          sda_oe = !tx_reg[7];
      default:                           sda_oe = 1'b0;
    endcase
  end

  // register bank, written by the host, restored by register reset
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regs_reg[0] <= RST_OVP_LIMIT;
      regs_reg[1] <= RST_OVP_ALARM;
      regs_reg[2] <= RST_OCP_LIMIT;
      regs_reg[3] <= RST_OCP_ALARM;
    end
    else if (reg_reset)
    begin
      regs_reg[0] <= RST_OVP_LIMIT;
      regs_reg[1] <= RST_OVP_ALARM;
      regs_reg[2] <= RST_OCP_LIMIT;
      regs_reg[3] <= RST_OCP_ALARM;
    end
    else if (wr_stb)
    begin
      if (ptr_reg == OFF_OVP_LIMIT)
        regs_reg[0] <= shift_reg;
      else if (ptr_reg == OFF_OVP_ALARM)
        regs_reg[1] <= shift_reg;
      else if (ptr_reg == OFF_OCP_LIMIT)
        regs_reg[2] <= shift_reg;
      else if (ptr_reg == OFF_OCP_ALARM)
        regs_reg[3] <= shift_reg;
    end
  end

  // overvoltage protection, reaching the limit trips
  blt_threshold_check #(
    .MEAS_W   (VOLT_W),
    .OFFSET   (OVP_OFFSET_UV),
    .STEP     (OVP_STEP_UV),
    .MIN_CODE (NO_MIN_CODE),
    .STRICT   (1'b0)
  ) u_ovp (
    .clock    (clock),
    .rst_n    (rst_n),
    .code     (regs_reg[0][CODE_W-1:0]),
    .off      (regs_reg[0][DIS_BIT]),
    .meas     (vbat_uv),
    .trip_reg (ovp_trip)
  );

  // overvoltage alarm, rising above the threshold trips
  blt_threshold_check #(
    .MEAS_W   (VOLT_W),
    .OFFSET   (OVA_OFFSET_UV),
    .STEP     (OVA_STEP_UV),
    .MIN_CODE (NO_MIN_CODE),
    .STRICT   (1'b1)
  ) u_ova (
    .clock    (clock),
    .rst_n    (rst_n),
    .code     (regs_reg[1][CODE_W-1:0]),
    .off      (regs_reg[1][DIS_BIT]),
    .meas     (vbat_uv),
    .trip_reg (ova_trip)
  );

  // overcurrent protection, codes below the usable range clamp up
  blt_threshold_check #(
    .MEAS_W   (CURR_W),
    .OFFSET   (ZERO_OFFSET),
    .STEP     (OCP_STEP_DMA),
    .MIN_CODE (OCP_MIN_CODE),
    .STRICT   (1'b0)
  ) u_ocp (
    .clock    (clock),
    .rst_n    (rst_n),
    .code     (regs_reg[2][CODE_W-1:0]),
    .off      (regs_reg[2][DIS_BIT]),
    .meas     (ibat_dma),
    .trip_reg (ocp_trip)
  );

  // overcurrent alarm
  blt_threshold_check #(
    .MEAS_W   (CURR_W),
    .OFFSET   (ZERO_OFFSET),
    .STEP     (OCA_STEP_DMA),
    .MIN_CODE (NO_MIN_CODE),
    .STRICT   (1'b0)
  ) u_oca (
    .clock    (clock),
    .rst_n    (rst_n),
    .code     (regs_reg[3][CODE_W-1:0]),
    .off      (regs_reg[3][DIS_BIT]),
    .meas     (ibat_dma),
    .trip_reg (oca_trip)
  );

  assign prot_any = ovp_trip || ocp_trip;

  // protection: fets off while tripped, charge enable cleared on entry
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prot_d_reg     <= 1'b0;
      fets_off_reg   <= 1'b0;
      charge_enable_ctl_clr_reg <= 1'b0;
    end
    else
    begin
      prot_d_reg     <= prot_any;
      fets_off_reg   <= prot_any;
      charge_enable_ctl_clr_reg <= prot_any && !prot_d_reg;
    end
  end

  // interrupt low while any enabled alarm or protection is active
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      int_n_reg <= 1'b1;
    else
      int_n_reg <= !(ova_trip || oca_trip || prot_any);
  end

endmodule

/* dv/blt_limit_regs_assertions.sv */
// Purpose: port-level checks of the battery limit register block
// Assumes: one clock domain, reset async active low
// Notes:   thresholds are hidden here, only their lowest settings
module blt_limit_regs_chk
  import blt_pkg::*;
(
  input wire logic              clock,          // core clock
  input wire logic              rst_n,          // async reset, active low
  input wire logic              scl_in,         // i2c clock pin
  input wire logic              sda_out,        // sda drive value
  input wire logic              sda_oe,         // sda pull enable
  input wire logic [VOLT_W-1:0] vbat_uv,        // battery voltage
  input wire logic [CURR_W-1:0] ibat_dma,       // battery current
  input wire logic              fets_off_reg,   // fets turned off
  input wire logic              charge_enable_ctl_clr_reg, // charge enable clear
  input wire logic              int_n_reg       // interrupt, active low
);
  timeunit 1ns;
  timeprecision 1ps;

  // no protection may trip below the lowest programmable limits
  wire logic over_min = (vbat_uv >= VOLT_W'(OVP_OFFSET_UV)) ||
    (ibat_dma >= CURR_W'(OCP_MIN_CODE * OCP_STEP_DMA));

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_sda_stays_low:
    assert property (sda_out == 1'b0)
    else $error("sda drive value not low");
  a_oe_scl_low:
    assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda drive changed while scl high");
  a_oe_bounded:
    assert property ($rose(sda_oe) |-> ##[1:600] !sda_oe)
    else $error("sda held low too long");
  a_clr_at_rise:
    assert property (charge_enable_ctl_clr_reg == $rose(fets_off_reg))
    else $error("charge clear pulse not at protection start");
  a_clr_single:
    assert property (charge_enable_ctl_clr_reg |=> !charge_enable_ctl_clr_reg)
    else $error("charge clear pulse longer than a cycle");
  a_fets_int_low:
    assert property (fets_off_reg |-> !int_n_reg)
    else $error("protection active without interrupt");
  a_fets_cause:
    assert property (fets_off_reg |-> $past(over_min, 2))
    else $error("protection without a high reading");
  a_quiet_no_trip:
    assert property ((!over_min) [*3] |-> ##1 !fets_off_reg)
    else $error("protection while readings low");
  a_release_idle:
    assert property ($rose(rst_n) |-> int_n_reg && !fets_off_reg && !sda_oe)
    else $error("outputs not idle after reset");
endmodule

/* dv/blt_host_model.sv */
// Purpose: i2c host controller model driving scl and sda
// Assumes: the bench resolves the open-drain sda wire
// Notes:   pins change at falling clock edges; half sets the pace
module blt_host_model (
  input  wire logic clock,    // bench clock
  input  wire logic sda,      // resolved sda wire
  output logic      scl,      // scl pin
  output logic      sda_pull  // high pulls sda low
);
  timeunit 1ns;
  timeprecision 1ps;
  int half = 10; // clocks per scl phase, at least 8

  // bus idle: both lines high
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // wait a number of falling edges
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask

  // one scl pulse: data changes only while scl is low
  task automatic pulse(input logic b, output logic s);
    idle(2);
    sda_pull = !b;
    idle(half);
    scl = 1'b1;
    idle(half);
    s = sda;
    scl = 1'b0;
  endtask

  // eight bits msb first, ninth bit released or a read ack/nack
  task automatic xfer(input logic [7:0] d, input logic b9,
                      output logic [7:0] q, output logic s9);
    for (int i = 7; i >= 0; i--)
      pulse(d[i], q[i]);
    pulse(b9, s9);
  endtask

  // start or repeated start: sda falls while scl high
  task automatic start_c();
    sda_pull = 1'b0;
    idle(half);
    scl = 1'b1;
    idle(half);
    sda_pull = 1'b1;
    idle(half);
    scl = 1'b0;
  endtask

  // stop: sda rises while scl high
  task automatic stop_c();
    idle(2);
    sda_pull = 1'b1;
    idle(half);
    scl = 1'b1;
    idle(half);
    sda_pull = 1'b0;
    idle(half);
  endtask
endmodule

/* dv/tb_top.sv */
// Purpose: self-checking bench for the battery limit registers
// Assumes: host model on i2c, battery readings driven directly
// Notes:   inputs change at falling clock edges
module tb_top import blt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0]  ADDR_LO = 7'h10;      // arbitrary value
  localparam logic [6:0]  ADDR_HI = 7'h11;      // arbitrary value
  localparam logic [22:0] V_LOW   = 23'h2dc6c0; // under every limit
  logic              clock;
  logic              rst_n;
  logic              reg_reset;
  logic              strap;
  logic [VOLT_W-1:0] vbat;
  logic [CURR_W-1:0] ibat;
  logic              scl;
  logic              sda_pull;
  logic              sda_out;
  logic              sda_oe;
  logic              fets_off;
  logic              chg_clr;
  logic              int_n;
  logic [6:0]        my_addr;
  logic              exp_f;
  int                bad_count = 0;
  int                checks = 0;
  int                cyc = 0;
  wire logic         sda = !(sda_oe || sda_pull); // pulled-up wire

  blt_limit_regs #(.TARGET_ADDR_LO(ADDR_LO), .TARGET_ADDR_HI(ADDR_HI)) dut_u (
    .clock(clock), .rst_n(rst_n), .reg_reset(reg_reset), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(strap),
    .vbat_uv(vbat), .ibat_dma(ibat), .fets_off_reg(fets_off),
    .charge_enable_ctl_clr_reg(chg_clr), .int_n_reg(int_n));
  blt_host_model host_u (.clock(clock), .sda(sda), .scl(scl),
    .sda_pull(sda_pull));

  // free-running clock
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic check(input string what, input logic [22:0] seen,
                       input logic [22:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // cut a hung run short
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 32'hea60)
    begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic do_reset(input logic s);
    @(negedge clock);
    rst_n = 1'b0;
    strap = s;
    my_addr = s ? ADDR_HI : ADDR_LO;
    vbat = V_LOW;
    ibat = '0;
    exp_f = 1'b0;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    repeat (6) @(negedge clock);
  endtask

  // write transfer; nak is high if any byte went unacknowledged
  task automatic wr(input logic [6:0] a, input logic [7:0] p,
                    input logic [7:0] d [$], output logic nak);
    logic [7:0] q;
    logic       s;
    host_u.start_c();
    host_u.xfer({a, 1'b0}, 1'b1, q, nak);
    if (!nak)
    begin
      host_u.xfer(p, 1'b1, q, s);
      nak |= s;
      foreach (d[i])
      begin
        host_u.xfer(d[i], 1'b1, q, s);
        nak |= s;
      end
    end
    host_u.stop_c();
  endtask

  task automatic wl(input logic [7:0] p, input logic [7:0] d [$]);
    logic nak;
    wr(my_addr, p, d, nak);
    check("write ack", 23'(nak), 23'h0);
  endtask

  // pointer write, repeated start, then reads nacking the last byte
  task automatic rd(input logic [7:0] p, input logic [7:0] e [$]);
    logic [7:0] q;
    logic       s;
    host_u.start_c();
    host_u.xfer({my_addr, 1'b0}, 1'b1, q, s);
    host_u.xfer(p, 1'b1, q, s);
    host_u.start_c();
    host_u.xfer({my_addr, 1'b1}, 1'b1, q, s);
    foreach (e[i])
    begin
      host_u.xfer(8'hff, i == e.size() - 1, q, s);
      check("read byte", 23'(q), 23'(e[i]));
    end
    host_u.stop_c();
  endtask

  // apply readings, then judge outputs and count clear pulses
  task automatic meas(input logic [22:0] v, input logic [17:0] i,
                      input logic f, input logic n);
    int p;
    p = 0;
    vbat = v;
    ibat = i;
    repeat (4)
    begin
      @(negedge clock);
      p += int'(chg_clr === 1'b1);
    end
    check("fets off", 23'(fets_off), 23'(f));
    check("int_n", 23'(int_n), 23'(n));
    check("clear pulses", 23'(p), 23'(f && !exp_f));
    exp_f = f;
  endtask

  task automatic t_defaults();
    rd(8'h00, '{8'h5a, 8'h46, 8'h47, 8'h46, 8'hff});
    meas(V_LOW, '0, 1'b0, 1'b1);
    $display("test defaults done");
  endtask

  task automatic t_rw();
    logic nak;
    wl(8'h00, '{8'h81, 8'h05, 8'h8a, 8'h96});
    rd(8'h00, '{8'h81, 8'h05, 8'h8a, 8'h96});
    wl(8'h04, '{8'h12});
    rd(8'h03, '{8'h96, 8'hff, 8'hff});
    wr(ADDR_HI, 8'h00, '{8'h00}, nak);
    check("foreign address", 23'(nak), 23'h1);
    rd(8'h00, '{8'h81});
    $display("test read write done");
  endtask

  task automatic t_volt();
    logic [22:0] prot;
    logic [22:0] warn;
    prot = 23'(OVP_OFFSET_UV + 8'h10 * OVP_STEP_UV);
    warn = 23'(OVA_OFFSET_UV + 8'h05 * OVA_STEP_UV);
    wl(8'h00, '{8'h10, 8'h05, 8'h80, 8'h80});
    meas(warn, '0, 1'b0, 1'b1);
    meas(warn + 23'h1, '0, 1'b0, 1'b0);
    meas(prot - 23'h1, '0, 1'b0, 1'b0);
    meas(prot, '0, 1'b1, 1'b0);
    wl(8'h00, '{8'h90, 8'h85});
    meas(prot, '0, 1'b0, 1'b1);
    $display("test voltage done");
  endtask

  task automatic t_curr();
    logic [17:0] prot;
    logic [17:0] warn;
    prot = 18'(OCP_MIN_CODE * OCP_STEP_DMA);
    warn = 18'(8'h14 * OCA_STEP_DMA);
    wl(8'h00, '{8'h80, 8'h80, 8'h05, 8'h14});
    meas(V_LOW, warn - 18'h1, 1'b0, 1'b1);
    meas(V_LOW, warn, 1'b0, 1'b0);
    meas(V_LOW, prot - 18'h1, 1'b0, 1'b0);
    meas(V_LOW, prot, 1'b1, 1'b0);
    wl(8'h02, '{8'h85, 8'h94});
    meas(V_LOW, prot, 1'b0, 1'b1);
    $display("test current done");
  endtask

  task automatic t_regrst();
    @(negedge clock);
    reg_reset = 1'b1;
    @(negedge clock);
    reg_reset = 1'b0;
    rd(8'h00, '{8'h5a, 8'h46, 8'h47, 8'h46});
    $display("test register reset done");
  endtask

  task automatic t_strap();
    logic nak;
    do_reset(1'b1);
    host_u.half = 20;
    wr(ADDR_LO, 8'h00, '{8'h11}, nak);
    check("strapped address", 23'(nak), 23'h1);
    wl(8'h00, '{8'h33});
    rd(8'h00, '{8'h33, 8'h46});
    host_u.half = 10;
    $display("test strap done");
  endtask

  // main sequence
  initial
  begin
    rst_n = 1'b0;
    reg_reset = 1'b0;
    strap = 1'b0;
    vbat = V_LOW;
    ibat = '0;
    exp_f = 1'b0;
    my_addr = ADDR_LO;
    do_reset(1'b0);
    t_defaults();
    t_rw();
    t_volt();
    t_curr();
    t_regrst();
    t_strap();
    do_reset(1'b0);
    t_defaults();
    give_verdict();
  end
endmodule

bind blt_limit_regs blt_limit_regs_chk chk_u (
  .clock(clock), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .vbat_uv(vbat_uv), .ibat_dma(ibat_dma),
  .fets_off_reg(fets_off_reg), .charge_enable_ctl_clr_reg(charge_enable_ctl_clr_reg),
  .int_n_reg(int_n_reg));
